/* File: hw/irq_timer_pkg.sv */
// Constants for the interrupt status and stream compare block.
// Assumes a register access port (address, write, read strobes) from the serial interface.
`default_nettype none
package irq_timer_pkg;
    // ------------------------------------------------------------
    // Register offsets and widths
    // ------------------------------------------------------------
    localparam logic [7:0] STC_LOW_ADDR = 8'h23; // Stream timer compare low
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h24; // Interrupt status flags
    localparam int REG_W = 16; // Register data width
    localparam int TIMER_W = 24; // Event timer width
    localparam int PRIME_W = 16; // Prime compare width
    localparam logic [15:0] STC_LOW_RESET = 16'hffff; // Prime compare reset value
    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int BIT_PLL = 15;
    localparam int BIT_RAM_TXD = 14;
    localparam int BIT_ARB_RXD = 13;
    localparam int BIT_STRM_ERR = 12;
    localparam int BIT_ATTN = 10;
    localparam int BIT_DOZE = 9;
    localparam int BIT_CMP1 = 8;
    localparam int BIT_RX = 7;
    localparam int BIT_TX = 6;
    localparam int BIT_CMP3 = 4;
    localparam int BIT_CMP4 = 3;
    localparam int BIT_CMP2 = 2;
    // Bits that latch and clear on read (15 is latched apart, 11 reserved, 5, 1 and 0 elsewhere)
    localparam logic [15:0] STICKY_MASK = 16'h77dc;
endpackage
`default_nettype wire

/* File: hw/irq_status_and_stream_timer_compare.sv */
// Interrupt status register with clear-on-read and the stream-mode 16-bit timer compare.
// Assumes timer, compare values, masks and radio events come from logic on i_core_clk.
`default_nettype none
module irq_status_and_stream_timer_compare
    import irq_timer_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    input wire logic [23:0] i_event_timer,
    input wire logic [23:0] i_cmp1_value,
    input wire logic [23:0] i_second_compare_value,
    input wire logic [23:0] i_cmp3_value,
    input wire logic [23:0] i_cmp4_value,
    input wire logic i_cmp1_disable,
    input wire logic i_second_compare_disable,
    input wire logic i_cmp3_disable,
    input wire logic i_cmp4_disable,
    input wire logic i_stream_mode,
    input wire logic i_timer_trig_en,
    input wire logic i_doze_mode,
    input wire logic [15:0] i_irq_mask,
    input wire logic i_pll_unlock,
    input wire logic i_ram_addr_overrun,
    input wire logic i_ram_arb_busy,
    input wire logic i_stream_tx_done,
    input wire logic i_stream_rx_done,
    input wire logic i_stream_rx_overrun,
    input wire logic i_stream_tx_underrun,
    input wire logic i_attn_n,
    input wire logic i_powerup_done,
    input wire logic i_rx_event,
    input wire logic i_tx_event,
    input wire logic i_active_start,
    output logic o_seq_trigger,
    output logic o_doze_exit,
    output logic o_active_abort,
    output logic o_irq_n
);
    // ------------------------------------------------------------
    // Synchroniser for the attention pin
    // ------------------------------------------------------------
    logic [2:0] attn_sync_reg; // Three stages, bit 0 first
    logic attn_low_event; // Falling edge seen on stable stages
    logic attn_edge_arm_reg; // Set while the pin rests high

    // Shift the pin in; only the second stage reads the first, which may go metastable
    // Reset loads the idle high level so that release cannot look like a falling edge
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            attn_sync_reg <= 3'h7;
        end else begin
            attn_sync_reg <= {attn_sync_reg[1:0], i_attn_n};
        end
    end

    // Second and third agree low after third was high
    assign attn_low_event = ~attn_sync_reg[1] & ~attn_sync_reg[2] & attn_edge_arm_reg;

    // Arm on a steady high level, disarm once the low level has been reported
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            attn_edge_arm_reg <= 1'b0;
        end else if (attn_sync_reg[1] & attn_sync_reg[2]) begin
            attn_edge_arm_reg <= 1'b1;
        end else if (attn_low_event) begin
            attn_edge_arm_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Prime compare register
    // ------------------------------------------------------------
    logic [15:0] prime_compare_value_reg;
    logic stc_wr; // Write strobe to the prime compare register
    logic status_rd; // Read strobe on the status register

    assign stc_wr = i_reg_wr & (i_reg_addr == STC_LOW_ADDR);
    assign status_rd = i_reg_rd & (i_reg_addr == IRQ_STATUS_ADDR);

    // Host writes land at the edge that takes the write strobe
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prime_compare_value_reg <= STC_LOW_RESET;
        end else if (stc_wr) begin
            prime_compare_value_reg <= i_reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Timer comparators
    // ------------------------------------------------------------
    // Full-width compare with disable
    function automatic logic cmp_hit(input logic [23:0] value, input logic [23:0] timer, input logic dis);
        cmp_hit = ~dis & (value == timer);
    endfunction

    // Remember the last timer value: a match that stands for several cycles
    // would otherwise set its flag again after the host has read it
    logic timer_changed_reg; // Matches count once per timer value
    logic [23:0] timer_prev_reg;
    logic new_tick;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            timer_prev_reg <= 24'h0;
            timer_changed_reg <= 1'b0;
        end else begin
            timer_prev_reg <= i_event_timer;
            timer_changed_reg <= 1'b1;
        end
    end
    assign new_tick = ~timer_changed_reg | (timer_prev_reg != i_event_timer);

    logic cmp1_hit; // Compare-1 match on a new timer value
    logic cmp2_hit; // Full compare-2 match, packet mode only
    logic cmp3_hit; // Compare-3 match
    logic cmp4_hit; // Compare-4 match
    logic prime_hit; // Prime match on the low timer bits, stream mode only
    logic doze_hit; // Compare-2 match while dozing
    assign cmp1_hit = new_tick & cmp_hit(i_cmp1_value, i_event_timer, i_cmp1_disable);
    assign cmp3_hit = new_tick & cmp_hit(i_cmp3_value, i_event_timer, i_cmp3_disable);
    assign cmp4_hit = new_tick & cmp_hit(i_cmp4_value, i_event_timer, i_cmp4_disable);
    // Packet mode: full 24-bit compare-2; stream mode: prime against low bits
    assign cmp2_hit = new_tick & ~i_stream_mode
        & cmp_hit(i_second_compare_value, i_event_timer, i_second_compare_disable);
    assign prime_hit = new_tick & i_stream_mode & ~i_second_compare_disable
        & (prime_compare_value_reg == i_event_timer[PRIME_W-1:0]);
    assign doze_hit = new_tick & i_doze_mode
        & cmp_hit(i_second_compare_value, i_event_timer, i_second_compare_disable);

    // ------------------------------------------------------------
    // Status set terms and sticky flags
    // ------------------------------------------------------------
    logic [15:0] status_set; // One-cycle events per bit
    // Multiplexed bits take their source from the stream mode level
    always_comb begin
        status_set = 16'h0;
        status_set[BIT_RAM_TXD] = i_stream_mode ? i_stream_tx_done : i_ram_addr_overrun;
        status_set[BIT_ARB_RXD] = i_stream_mode ? i_stream_rx_done : i_ram_arb_busy;
        status_set[BIT_STRM_ERR] = i_stream_mode & (i_stream_rx_overrun | i_stream_tx_underrun);
        status_set[BIT_ATTN] = attn_low_event | i_powerup_done;
        status_set[BIT_DOZE] = doze_hit;
        status_set[BIT_CMP1] = cmp1_hit;
        status_set[BIT_RX] = i_rx_event;
        status_set[BIT_TX] = i_tx_event;
        status_set[BIT_CMP3] = cmp3_hit;
        status_set[BIT_CMP4] = cmp4_hit;
        status_set[BIT_CMP2] = cmp2_hit | prime_hit;
    end

    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic pll_latched_reg; // Unlock seen since last status read
    logic pll_latched_next;

    // Set wins over the clear from a read in the same cycle
    assign status_next = ((status_rd ? 16'h0 : status_reg) | status_set) & STICKY_MASK;
    assign pll_latched_next = (status_rd ? 1'b0 : pll_latched_reg) | i_pll_unlock;

    // Flags hold until the host reads them; an event in the read cycle survives
    // so that no event is lost between the read and the next one
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            status_reg <= 16'h0;
            pll_latched_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            pll_latched_reg <= pll_latched_next;
        end
    end

    // Bit 15 is kept apart so that it re-sets every cycle while the loop stays unlocked
    logic [15:0] status_view; // Read view: bit 15 follows the latched unlock
    always_comb begin
        status_view = status_reg;
        status_view[BIT_PLL] = pll_latched_reg;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Reads of other addresses keep the last data, so the host may sample it again
    logic [15:0] rdata_next;
    assign rdata_next = status_rd ? status_view
        : (i_reg_rd & (i_reg_addr == STC_LOW_ADDR)) ? prime_compare_value_reg : o_reg_rdata;

    // All outputs leave flip-flops; the request is built from next-state terms
    // so that it follows the flags without a cycle of lag
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0;
            o_seq_trigger <= 1'b0;
            o_doze_exit <= 1'b0;
            o_active_abort <= 1'b0;
            o_irq_n <= 1'b1;
        end else begin
            o_reg_rdata <= rdata_next;
            o_seq_trigger <= i_timer_trig_en & (cmp2_hit | prime_hit);
            o_doze_exit <= doze_hit;
            o_active_abort <= i_active_start & pll_latched_reg;
            o_irq_n <= ~(|({pll_latched_next, status_next[BIT_PLL-1:0]} & i_irq_mask));
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_prime_trigger: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_timer_trig_en & prime_hit) |=> o_seq_trigger) else $error("prime match gave no trigger");
    a_packet_ignores_prime: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (~i_stream_mode & ~cmp2_hit) |=> ~o_seq_trigger) else $error("trigger without packet match");
    a_read_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (status_rd & status_set == 16'h0) |=> status_reg == 16'h0) else $error("read left bits set");
    a_cmp1_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cmp1_hit |=> status_reg[BIT_CMP1]) else $error("compare-1 flag missing");
    a_doze_exit: assert property (@(posedge i_core_clk) disable iff (i_rst)
        doze_hit |=> (o_doze_exit & status_reg[BIT_DOZE])) else $error("doze match not handled");
    a_abort_unlock: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_active_start & pll_latched_reg) |=> o_active_abort) else $error("active op not aborted");
    a_stream_err: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_stream_mode & i_stream_rx_overrun) |=> status_reg[BIT_STRM_ERR]) else $error("overrun lost");
    a_irq_release: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (status_rd & status_set == 16'h0 & ~i_pll_unlock) |=> o_irq_n) else $error("request not released");
    // Prime compare gating and the trigger
    a_prime_stream_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ~i_stream_mode |-> ~prime_hit) else $error("prime match outside stream mode");
    a_prime_disabled: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_second_compare_disable |-> ~prime_hit) else $error("prime match while disabled");
    a_stream_no_cmp2: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_stream_mode |-> ~cmp2_hit) else $error("full compare-2 used in stream mode");
    a_trig_needs_enable: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ~i_timer_trig_en |=> ~o_seq_trigger) else $error("trigger without enable");
    a_prime_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        prime_hit |=> status_reg[BIT_CMP2]) else $error("prime flag missing");
    a_cmp2_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cmp2_hit |=> status_reg[BIT_CMP2]) else $error("compare-2 flag missing");
    a_cmp3_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cmp3_hit |=> status_reg[BIT_CMP3]) else $error("compare-3 flag missing");
    a_cmp4_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cmp4_hit |=> status_reg[BIT_CMP4]) else $error("compare-4 flag missing");
    // Read data and the request line
    a_rdata_status: assert property (@(posedge i_core_clk) disable iff (i_rst)
        status_rd |=> (o_reg_rdata == $past(status_view))) else $error("status read data wrong");
    a_rdata_prime: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_reg_rd & (i_reg_addr == STC_LOW_ADDR)) |=> (o_reg_rdata == $past(prime_compare_value_reg)))
        else $error("prime read data wrong");
    a_pll_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_pll_unlock |=> pll_latched_reg) else $error("unlock not latched");
    a_irq_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (~status_rd & (|(status_view & i_irq_mask))) |=> ~o_irq_n) else $error("request dropped early");
    a_abort_needs_unlock: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ~pll_latched_reg |=> ~o_active_abort) else $error("abort while locked");
    a_no_doze_exit: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ~doze_hit |=> ~o_doze_exit) else $error("doze exit without match");
    // Event flags: each event sets its bit one edge later
    a_attn_event: assert property (@(posedge i_core_clk) disable iff (i_rst)
        attn_low_event |=> status_reg[BIT_ATTN]) else $error("attention flag missing");
    a_powerup_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_powerup_done |=> status_reg[BIT_ATTN]) else $error("power-up flag missing");
    a_ram_overrun: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (~i_stream_mode & i_ram_addr_overrun) |=> status_reg[BIT_RAM_TXD]) else $error("overrun flag missing");
    a_stream_tx_done: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_stream_mode & i_stream_tx_done) |=> status_reg[BIT_RAM_TXD]) else $error("tx done flag missing");
    a_arb_busy: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (~i_stream_mode & i_ram_arb_busy) |=> status_reg[BIT_ARB_RXD]) else $error("busy flag missing");
    a_stream_rx_done: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_stream_mode & i_stream_rx_done) |=> status_reg[BIT_ARB_RXD]) else $error("rx done flag missing");
    a_tx_underrun: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_stream_mode & i_stream_tx_underrun) |=> status_reg[BIT_STRM_ERR]) else $error("underrun lost");
    a_rx_word: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_rx_event |=> status_reg[BIT_RX]) else $error("receive flag missing");
    a_tx_word: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_tx_event |=> status_reg[BIT_TX]) else $error("transmit flag missing");
    c_prime_match: cover property (@(posedge i_core_clk) disable iff (i_rst) prime_hit);
    c_irq_asserted: cover property (@(posedge i_core_clk) disable iff (i_rst) $fell(o_irq_n));
    c_set_on_read: cover property (@(posedge i_core_clk) disable iff (i_rst) status_rd & (|status_set));
    c_doze_exit: cover property (@(posedge i_core_clk) disable iff (i_rst) o_doze_exit);
    c_attn_event: cover property (@(posedge i_core_clk) disable iff (i_rst) attn_low_event);
endmodule
`default_nettype wire

/* File: verification/host_mcu_model.sv */
// Host model: issues register requests and holds the host-side settings.
// Assumes the block takes requests on the rising edge of i_clk.
`default_nettype none
module host_mcu_model
    import irq_timer_pkg::*;
(
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_wdata,
    output logic [15:0] o_mask,
    output logic o_cmp2_dis,
    output logic o_trig_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------
    // Idle bus and settings
    // --------------------------------------------
    initial begin
        {o_addr, o_wr, o_rd, o_wdata} = '0;
        o_cmp2_dis = 1'b0;
        o_mask = 16'hffff;
        o_trig_en = 1'b1;
    end
    // Mask and trigger enable change at a falling edge
    task automatic set_host(input logic [15:0] m, input logic t);
        @(negedge i_clk);
        o_mask = m;
        o_trig_en = t;
    endtask
    // Compare-2 disable changes at a falling edge
    task automatic set_disable(input logic v);
        @(negedge i_clk);
        o_cmp2_dis = v;
    endtask
    // One request across one rising edge; released address and data lines show the inverse, strobes go low
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] wd, output logic [15:0] rv);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = wd;
        o_wr = w;
        o_rd = !w;
        @(negedge i_clk);
        rv = i_rdata;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~wd;
    endtask
endmodule
`default_nettype wire

/* File: verification/irq_status_and_stream_timer_compare_test.sv */
// Bench for the status flags and stream compare block, accessed through the host model.
// Assumes inputs change at falling edges of the core clock.
`default_nettype none
module irq_status_and_stream_timer_compare_test
    import irq_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, mode, doze, pll, attn_n, trig, dexit, abort, irq_n, c2dis, ten;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, mask, d;
    logic [23:0] timer, c1, c2, c3, c4;
    logic [9:0] ev; // Event pulses; bit 9 starts an active operation
    int failures = 0, cmp_count = 0, trig_n = 0, abort_n = 0, doze_n = 0, t0;
    // Entries: mode, event index, expected status bit
    localparam logic [8:0] TAB [12] = '{9'h00e, 9'h01d, 9'h06a, 9'h077, 9'h086, 9'h12e, 9'h13d, 9'h14c,
        9'h15c, 9'h16a, 9'h177, 9'h186};
    irq_status_and_stream_timer_compare u_dut (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_event_timer(timer), .i_cmp1_value(c1),
        .i_second_compare_value(c2), .i_cmp3_value(c3), .i_cmp4_value(c4), .i_cmp1_disable(1'b0),
        .i_second_compare_disable(c2dis), .i_cmp3_disable(1'b0), .i_cmp4_disable(1'b0), .i_stream_mode(mode),
        .i_timer_trig_en(ten), .i_doze_mode(doze), .i_irq_mask(mask), .i_pll_unlock(pll),
        .i_ram_addr_overrun(ev[0]), .i_ram_arb_busy(ev[1]), .i_stream_tx_done(ev[2]), .i_stream_rx_done(ev[3]),
        .i_stream_rx_overrun(ev[4]), .i_stream_tx_underrun(ev[5]), .i_attn_n(attn_n), .i_powerup_done(ev[6]),
        .i_rx_event(ev[7]), .i_tx_event(ev[8]), .i_active_start(ev[9]), .o_seq_trigger(trig),
        .o_doze_exit(dexit), .o_active_abort(abort), .o_irq_n(irq_n));
    host_mcu_model u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
        .o_mask(mask), .o_cmp2_dis(c2dis), .o_trig_en(ten));
    // --------------------------------------------
    // Clock, pulse counters and watchdog
    // --------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        trig_n <= trig_n + int'(trig);
        abort_n <= abort_n + int'(abort);
        doze_n <= doze_n + int'(dexit);
    end
    initial begin
        #20000;
        failures++;
        complete_run();
    end
    // --------------------------------------------
    // Helpers
    // --------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
        u_host.access(1'b0, a, 16'h0000, d);
        check(d & m, exp);
    endtask
    task automatic pulse(input int n);
        @(negedge clk);
        ev = 10'h001 << n;
        @(negedge clk);
        ev = 10'h000;
    endtask
    // New timer value, then time for the match to land
    task automatic step(input logic [23:0] v);
        @(negedge clk);
        timer = v;
        repeat (3) @(negedge clk);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // --------------------------------------------
    // Tests
    // --------------------------------------------
    initial begin
        rst = 1'b1;
        {mode, doze, pll, ev, timer} = '0;
        attn_n = 1'b1;
        {c1, c2, c3, c4} = {4{24'hffffff}};
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd_chk(STC_LOW_ADDR, 16'hffff, STC_LOW_RESET);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0000);
        u_host.access(1'b1, STC_LOW_ADDR, 16'h1234, d);
        u_host.access(1'b1, IRQ_STATUS_ADDR, 16'hffff, d);
        rd_chk(STC_LOW_ADDR, 16'hffff, 16'h1234);
        rd_chk(8'h50, 16'hffff, 16'h1234);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0000);
        $display("test registers done");
        foreach (TAB[i]) begin
            mode = TAB[i][8];
            pulse(int'(TAB[i][7:4]));
            check({15'h0, irq_n}, 16'h0000);
            rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0001 << TAB[i][3:0]);
            check({15'h0, irq_n}, 16'h0001);
        end
        u_host.set_host(16'h0000, 1'b1);
        pulse(7);
        check({15'h0, irq_n}, 16'h0001);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0080);
        $display("test events done");
        u_host.set_host(16'h7fff, 1'b1);
        pll = 1'b1;
        t0 = abort_n;
        pulse(9);
        check({15'h0, irq_n}, 16'h0001);
        rd_chk(IRQ_STATUS_ADDR, 16'h8000, 16'h8000);
        check(16'(abort_n - t0), 16'h0001);
        pll = 1'b0;
        u_host.access(1'b0, IRQ_STATUS_ADDR, 16'h0000, d);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0000);
        pulse(9);
        repeat (2) @(negedge clk);
        check(16'(abort_n - t0), 16'h0001);
        u_host.set_host(16'hffff, 1'b1);
        pll = 1'b1;
        repeat (3) @(negedge clk);
        check({15'h0, irq_n}, 16'h0000);
        pll = 1'b0;
        u_host.access(1'b0, IRQ_STATUS_ADDR, 16'h0000, d);
        u_host.access(1'b0, IRQ_STATUS_ADDR, 16'h0000, d);
        $display("test unlock done");
        {c1, c2, c3, c4} = {24'h10, 24'h40, 24'h20, 24'h30};
        mode = 1'b0;
        step(24'h000010);
        step(24'h000020);
        step(24'h000030);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0118);
        doze = 1'b1;
        t0 = doze_n;
        step(24'h000040);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0204);
        check(16'(doze_n - t0), 16'h0001);
        doze = 1'b0;
        $display("test compares done");
        mode = 1'b1;
        t0 = trig_n;
        step(24'hab1234);
        check(16'(trig_n - t0), 16'h0001);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0004);
        mode = 1'b0;
        step(24'h000000);
        step(24'hab1234);
        check(16'(trig_n - t0), 16'h0001);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0000);
        u_host.set_host(16'hffff, 1'b0);
        mode = 1'b1;
        step(24'h000000);
        step(24'h7f1234);
        check(16'(trig_n - t0), 16'h0001);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0004);
        u_host.set_host(16'hffff, 1'b1);
        u_host.set_disable(1'b1);
        step(24'h000000);
        step(24'hcd1234);
        check(16'(trig_n - t0), 16'h0001);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0000);
        u_host.set_disable(1'b0);
        mode = 1'b0;
        attn_n = 1'b0;
        repeat (6) @(negedge clk);
        rd_chk(IRQ_STATUS_ADDR, 16'hffff, 16'h0400);
        attn_n = 1'b1;
        $display("test prime and attention done");
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd_chk(STC_LOW_ADDR, 16'hffff, STC_LOW_RESET);
        $display("test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
